// file: hw/sbr_channel_status.v
// Serial channel buffer-ready and receive status head block, AHB-Lite slave
//
// Overview of operation
// [R1] Transmit-ready sets while transmit byte count is at or below activation.
// [R2] Transmit-ready clears when count reaches deactivation level plus one.
// [R3] Deactivation applies only when its level is below the activation level.
// [R4] Threshold bits 7 to 5 read zero; software writes zero.
// [R5] RX reset, channel reset or stop mode clear both status views.
// [R6] The status views never raise an interrupt.
// [R7] Head view bits 7 to 2 mirror head status entry, receive layout.
// [R8] Second view bits 7 to 2 mirror second status entry.
// [R9] Status valid when data readable; each read advances to next entry.
// [R10] Head view bit 0 shows data present in head stage.
// [R11] Second view bit 0 shows data present in second stage.
// [R12] Bit 1 of both views reads zero; software writes zero.
// [R13] Modes 0, 2, 3: receive status is OR of head and second.
// [R14] The two present bits give none, one, or two-plus bytes.
// [R15] Software keeps deactivation at 1EH or less, checks ready before writes.
// [R16] Both views read zero after reset before data arrives.
// [R17] Upper status bits carry per-character protocol error flags.
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sbr_defines.vh"
module sbr_channel_status #(
  parameter RX_DEPTH = `SBR_RX_DEPTH
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire rx_valid,
  output wire rx_ready,
  input wire [7:0] rx_data,
  input wire [5:0] rx_flags,
  input wire [5:0] tx_byte_count,
  output wire tx_buffer_ready_flag
);
  localparam CW = $clog2(RX_DEPTH) + 1;

  // Bus address phase captured for the data phase
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;
  wire addr_phase;
  wire rd_now;
  wire wr_data_phase;

  // Software-visible state
  reg [4:0] act_reg;
  reg [4:0] act_next;
  reg [4:0] deact_reg;
  reg [4:0] deact_next;
  reg stop_reg;
  reg stop_next;
  reg [1:0] mode_reg;
  reg [1:0] mode_next;
  reg rx_reset_pulse;
  reg ch_reset_pulse;

  // Receive buffer
  wire fifo_clear;
  wire head_valid;
  wire second_valid;
  wire [13:0] head_word;
  wire [13:0] second_word;
  wire [CW-1:0] rx_count;
  wire rx_pop;

  // Views and read mux
  wire [7:0] head_view;
  wire [7:0] second_view;
  wire [7:0] rx_status_view;
  reg [31:0] rdata_next;

  function [7:0] view_byte;
    input present;
    input [5:0] flags;
    begin
      // Flags only while data is there, bit 1 always zero
      view_byte = present ? {flags, 1'b0, 1'b1} : 8'h00; // see [R9] [R12]
    end
  endfunction

  function [31:0] thr_word;
    input [4:0] level;
    begin
      thr_word = {27'h0000000, level}; // see [R4]
    end
  endfunction

  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_now = addr_phase && !hwrite;
  assign wr_data_phase = wr_pend_reg;

  // Flush while any of the clearing conditions stands
  assign fifo_clear = rx_reset_pulse || ch_reset_pulse || stop_reg; // see [R5]

  // A read of the data register consumes the head entry
  assign rx_pop = rd_now &&
    (haddr[7:0] == `SBR_OFS_RX_DATA) && (haddr[31:8] == 24'h000000); // see [R9]

  sbr_fifo #(
    .W(14),
    .DEPTH(RX_DEPTH)
  ) u_rx_fifo (
    .clk(hclk),
    .rst_n(hresetn),
    .clear(fifo_clear),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({rx_flags, rx_data}),
    .out_valid(head_valid),
    .out_ready(rx_pop),
    .out_data(head_word),
    .second_valid(second_valid),
    .second_data(second_word),
    .count(rx_count)
  );

  // Flags keep receive layout: async parity/framing/overrun,
  // byte sync checksum, bit sync end/short/abort/residual
  assign head_view = view_byte(head_valid, head_word[13:8]); // see [R7] [R10] [R17]
  assign second_view = view_byte(second_valid, second_word[13:8]); // see [R8] [R11]

  // Mode 1 reads byte by byte, so only the head matters there
  assign rx_status_view = (mode_reg == `SBR_MODE_BYTE_ONLY) ? head_view :
    {head_view[7:2] | second_view[7:2], 2'b00}; // see [R13]

  // Views feed only the read mux; no interrupt path exists
  // see [R6]

  sbr_tx_ready u_tx_ready (
    .clk(hclk),
    .rst_n(hresetn),
    .clear(ch_reset_pulse),
    .byte_count(tx_byte_count),
    .activate_level(act_reg),
    .deactivate_level(deact_reg),
    .ready_flag(tx_buffer_ready_flag)
  );

  // Register writes land in the data phase
  always @* begin
    act_next = act_reg;
    deact_next = deact_reg;
    stop_next = stop_reg;
    mode_next = mode_reg;
    if (wr_data_phase) begin
      case (wr_addr_reg)
        `SBR_OFS_ACT: begin
          act_next = hwdata[`SBR_THR_MSB:0]; // see [R4]
        end
        `SBR_OFS_DEACT: begin
          deact_next = hwdata[`SBR_THR_MSB:0]; // see [R4]
        end
        `SBR_OFS_CTRL: begin
          stop_next = hwdata[`SBR_CTRL_STOP_BIT];
          mode_next = hwdata[`SBR_CTRL_MODE_MSB:`SBR_CTRL_MODE_LSB];
        end
        default: begin
          act_next = act_reg;
        end
      endcase
    end
  end

  // Read data; thresholds forwarded so a write is seen at once
  always @* begin
    rdata_next = 32'h00000000;
    if (haddr[31:8] == 24'h000000) begin
      case (haddr[7:0])
        `SBR_OFS_ACT: begin
          rdata_next = thr_word(act_next);
        end
        `SBR_OFS_DEACT: begin
          rdata_next = thr_word(deact_next);
        end
        `SBR_OFS_HEAD_VIEW: begin
          rdata_next = {24'h000000, head_view};
        end
        `SBR_OFS_SECOND_VIEW: begin
          rdata_next = {24'h000000, second_view};
        end
        `SBR_OFS_CTRL: begin
          rdata_next = {27'h0000000, mode_next, stop_next, 2'b00};
        end
        `SBR_OFS_STAT: begin
          rdata_next = {8'h00, {(8-CW){1'b0}}, rx_count,
            2'b00, tx_byte_count, 7'h00, tx_buffer_ready_flag};
        end
        `SBR_OFS_RX_STATUS: begin
          rdata_next = {24'h000000, rx_status_view};
        end
        `SBR_OFS_RX_DATA: begin
          // Empty buffer reads zero rather than stale data
          rdata_next = {24'h000000, head_valid ? head_word[7:0] : 8'h00};
        end
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h000000);
      if (addr_phase) begin
        wr_addr_reg <= haddr[7:0];
      end
      if (rd_now) begin
        hrdata <= rdata_next;
      end
    end
  end

  // Command bits act once and read back as zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_reg <= `SBR_THR_RESET;
      deact_reg <= `SBR_THR_RESET;
      stop_reg <= 1'b0;
      mode_reg <= `SBR_MODE_RESET;
      rx_reset_pulse <= 1'b0;
      ch_reset_pulse <= 1'b0;
    end else begin
      act_reg <= act_next;
      deact_reg <= deact_next;
      stop_reg <= stop_next;
      mode_reg <= mode_next;
      rx_reset_pulse <= wr_data_phase && (wr_addr_reg == `SBR_OFS_CTRL) &&
        hwdata[`SBR_CTRL_RX_RESET_BIT]; // see [R5]
      ch_reset_pulse <= wr_data_phase && (wr_addr_reg == `SBR_OFS_CTRL) &&
        hwdata[`SBR_CTRL_CH_RESET_BIT]; // see [R5]
    end
  end

  // Present bits: 00 none, 01 one byte, 11 two or more
  // see [R14] [R16]

endmodule // sbr_channel_status
`default_nettype wire

// file: hw/sbr_defines.vh
// Offsets, fields and reset values of the serial buffer status block
`ifndef SBR_DEFINES_VH
`define SBR_DEFINES_VH
`define SBR_OFS_ACT 8'h00
`define SBR_OFS_DEACT 8'h04
`define SBR_OFS_HEAD_VIEW 8'h08
`define SBR_OFS_SECOND_VIEW 8'h0C
`define SBR_OFS_CTRL 8'h10
`define SBR_OFS_STAT 8'h14
`define SBR_OFS_RX_STATUS 8'h18
`define SBR_OFS_RX_DATA 8'h1C
`define SBR_THR_MSB 4
`define SBR_THR_RESET 5'h00
`define SBR_VIEW_STAT_LSB 2
`define SBR_VIEW_PRESENT_BIT 0
`define SBR_CTRL_RX_RESET_BIT 0
`define SBR_CTRL_CH_RESET_BIT 1
`define SBR_CTRL_STOP_BIT 2
`define SBR_CTRL_MODE_LSB 3
`define SBR_CTRL_MODE_MSB 4
`define SBR_MODE_RESET 2'h0
`define SBR_MODE_BYTE_ONLY 2'h1
`define SBR_STAT_TX_BUFFER_READY_FLAG_BIT 0
`define SBR_STAT_TXCNT_LSB 8
`define SBR_STAT_RXCNT_LSB 16
`define SBR_RX_DEPTH 4
`endif

// file: hw/sbr_fifo.v
// Receive buffer FIFO holding data with its status, head and second visible
`timescale 1ns/1ps
`default_nettype none
module sbr_fifo #(
  parameter W = 14,
  parameter DEPTH = 4
) (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire in_valid,
  output reg in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data,
  output wire second_valid,
  output wire [W-1:0] second_data,
  output wire [((DEPTH > 1) ? $clog2(DEPTH) : 1):0] count
);
  localparam AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr_reg;
  reg [AW-1:0] wr_ptr_reg;
  reg [AW:0] count_reg;
  reg [AW:0] count_next;
  wire push;
  wire pop;
  function [AW-1:0] inc_ptr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH - 1) begin
        inc_ptr = {AW{1'b0}};
      end else begin
        inc_ptr = p + 1'b1;
      end
    end
  endfunction
  assign push = in_valid && in_ready && !clear;
  assign pop = out_valid && out_ready && !clear;
  assign out_valid = (count_reg != 0);
  assign second_valid = (count_reg > 1);
  assign out_data = mem[rd_ptr_reg];
  assign second_data = mem[inc_ptr(rd_ptr_reg)];
  assign count = count_reg;
  always @* begin
    count_next = count_reg;
    if (clear) begin
      count_next = {(AW+1){1'b0}};
    end else if (push && !pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop && !push) begin
      count_next = count_reg - 1'b1;
    end
  end
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  // Ready is registered so the source sees a clean, glitch-free stall
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_ptr_reg <= {AW{1'b0}};
      wr_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
    end else begin
      count_reg <= count_next;
      in_ready <= (count_next < DEPTH);
      if (clear) begin
        rd_ptr_reg <= {AW{1'b0}};
        wr_ptr_reg <= {AW{1'b0}};
      end else begin
        if (push) begin
          wr_ptr_reg <= inc_ptr(wr_ptr_reg);
        end
        if (pop) begin
          rd_ptr_reg <= inc_ptr(rd_ptr_reg);
        end
      end
    end
  end
endmodule // sbr_fifo
`default_nettype wire

// file: hw/sbr_tx_ready.v
// Transmit-ready flag from the two byte-count thresholds
`timescale 1ns/1ps
`default_nettype none
module sbr_tx_ready (
  input wire clk,
  input wire rst_n,
  input wire clear,
  input wire [5:0] byte_count,
  input wire [4:0] activate_level,
  input wire [4:0] deactivate_level,
  output reg ready_flag
);
  wire set_hit;
  wire clr_hit;
  assign set_hit = ({1'b0, activate_level} >= byte_count); // see [R1]
  // Deactivation only counts when its level sits below activation
  assign clr_hit = (deactivate_level < activate_level) &&
    (byte_count >= ({1'b0, deactivate_level} + 6'h01)); // see [R2] [R3]
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_flag <= 1'b0;
    end else if (clear) begin
      ready_flag <= 1'b0;
    end else if (set_hit) begin
      ready_flag <= 1'b1; // see [R1]
    end else if (clr_hit) begin
      ready_flag <= 1'b0; // see [R2] [R3]
    end
  end
endmodule // sbr_tx_ready
`default_nettype wire

// file: verification/sbr_rx_source.sv
// Receive byte source in front of the status block
`timescale 1ns/1ps
`default_nettype none
module sbr_rx_source (
  input wire logic hclk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic [5:0] rx_flags
);
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_flags = 6'h00;
  end
  // Offer held until taken or for at most 40 cycles; after release the lines carry the inverse
  task automatic send(input logic [7:0] d, input logic [5:0] f,
                      input int slow, output logic ok);
    int i;
    ok = 1'b0;
    repeat (slow) @(posedge hclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_flags <= f;
    for (i = 0; i < 40 && !ok; i++) begin
      @(posedge hclk);
      ok = rx_ready;
    end
    rx_valid <= 1'b0;
    rx_data <= ~d;
    rx_flags <= ~f;
  endtask
endmodule // sbr_rx_source
`default_nettype wire

// file: verification/sbr_channel_status_assertions.sv
// Port-level checks of the serial buffer status block
`timescale 1ns/1ps
`default_nettype none
module sbr_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rx_ready,
  input wire logic [5:0] tx_byte_count,
  input wire logic tx_buffer_ready_flag
);
  logic [7:0] a_q;
  logic rd_q;
  logic wr_q;
  logic [4:0] act;
  logic [4:0] dea;
  // Shadow copies of the thresholds, taken from the bus
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 8'h00;
      act <= 5'h00;
      dea <= 5'h00;
    end else begin
      rd_q <= hsel && htrans[1] && !hwrite;
      wr_q <= hsel && htrans[1] && hwrite;
      a_q <= haddr[7:0];
      if (wr_q && a_q == 8'h00) act <= hwdata[4:0];
      if (wr_q && a_q == 8'h04) dea <= hwdata[4:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_of(logic [7:0] a);
    rd_q && a_q == a;
  endsequence
  a_resp_okay: assert property (!hresp) else $error("bad response");
  a_no_wait: assert property (hreadyout) else $error("wait state");
  a_tx_set: assert property (
    tx_byte_count <= act |=> tx_buffer_ready_flag) else $error("no set");
  a_tx_clear: assert property (
    tx_byte_count > dea && dea < act && tx_byte_count > act
    |=> !tx_buffer_ready_flag) else $error("no clear");
  a_tx_hold: assert property (
    tx_byte_count > act && dea >= act |=> $stable(tx_buffer_ready_flag))
    else $error("flag moved");
  a_thr_reserved: assert property (
    rd_of(8'h00) or rd_of(8'h04) |-> hrdata[31:5] == 27'h0)
    else $error("threshold high bits");
  a_view_reserved: assert property (
    rd_q && a_q[7:3] == 5'h01 |-> hrdata[31:8] == 24'h0 && !hrdata[1])
    else $error("view reserved bits");
  a_rx_up: assert property ($rose(hresetn) |-> ##[1:2] rx_ready)
    else $error("receive not ready");
endmodule // sbr_checker
bind sbr_channel_status sbr_checker chk (.*);
`default_nettype wire

// file: verification/sbr_channel_status_bench.sv
// Self-checking bench of the serial buffer status block
`timescale 1ns/1ps
`default_nettype none
module sbr_channel_status_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [5:0] cnt = 6'h00;
  logic [7:0] rx_data;
  logic [5:0] rx_flags;
  logic hreadyout, hresp, rx_valid, rx_ready, flag, ok;
  int n_fail = 0;
  int cmp_count = 0;
  always #5 hclk = ~hclk;
  sbr_channel_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .rx_flags(rx_flags),
    .tx_byte_count(cnt), .tx_buffer_ready_flag(flag));
  sbr_rx_source src (.hclk(hclk), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_flags(rx_flags));
  task complete_run;
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task wt;
    for (int i = 0; i < 20; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_fail++;
    complete_run;
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wt;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task row(input logic [4:0] a, input logic [4:0] d, input logic [5:0] c,
           input logic e);
    ahb(1'b1, 8'h00, {27'h0, a});
    ahb(1'b1, 8'h04, {27'h0, d});
    cnt <= c;
    repeat (3) @(posedge hclk);
    chk({31'h0, flag}, {31'h0, e});
  endtask
  task t_reset;
    rdc(8'h08, 32'h0);
    rdc(8'h0C, 32'h0);
    rdc(8'h40, 32'h0);
    // Software keeps reserved threshold bits at zero
    ahb(1'b1, 8'h00, 32'h0000001F);
    rdc(8'h00, 32'h1F);
    ahb(1'b1, 8'h04, 32'h0000001F);
    rdc(8'h04, 32'h1F);
  endtask
  task t_tx;
    row(5'h05, 5'h02, 6'h05, 1'b1);
    row(5'h05, 5'h02, 6'h06, 1'b0);
    row(5'h05, 5'h02, 6'h03, 1'b1);
    row(5'h05, 5'h02, 6'h06, 1'b0);
    row(5'h05, 5'h07, 6'h14, 1'b0);
    row(5'h05, 5'h07, 6'h04, 1'b1);
    row(5'h05, 5'h07, 6'h14, 1'b1);
    row(5'h1F, 5'h1E, 6'h1F, 1'b1);
    row(5'h1F, 5'h1E, 6'h20, 1'b0);
  endtask
  task t_rx;
    src.send(8'hA1, 6'h15, 1, ok);
    src.send(8'hB2, 6'h2A, 1, ok);
    src.send(8'hC3, 6'h33, 1, ok);
    rdc(8'h08, 32'h55);
    rdc(8'h0C, 32'hA9);
    rdc(8'h18, 32'hFC);
    rdc(8'h1C, 32'hA1);
    rdc(8'h08, 32'hA9);
    rdc(8'h0C, 32'hCD);
    rdc(8'h1C, 32'hB2);
    rdc(8'h08, 32'hCD);
    rdc(8'h0C, 32'h00);
    rdc(8'h1C, 32'hC3);
    rdc(8'h08, 32'h00);
    for (int i = 0; i < 4; i++) begin
      src.send(8'h10, 6'h01, 1, ok);
      chk({31'h0, ok}, 32'h1);
    end
    src.send(8'hEE, 6'h02, 1, ok);
    chk({31'h0, ok}, 32'h0);
    // Byte-only mode shows the head view alone, present bit included
    ahb(1'b1, 8'h10, 32'h00000008);
    rdc(8'h18, 32'h05);
  endtask
  task t_clear;
    for (int k = 0; k < 3; k++) begin
      src.send(8'h21, 6'h04, 1, ok);
      src.send(8'h22, 6'h08, 1, ok);
      ahb(1'b1, 8'h10, 32'h1 << k);
      repeat (3) @(posedge hclk);
      rdc(8'h08, 32'h0);
      rdc(8'h0C, 32'h0);
    end
    ahb(1'b1, 8'h10, 32'h0);
  endtask
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_tx;
    t_rx;
    t_clear;
    complete_run;
  end
endmodule // sbr_channel_status_bench
`default_nettype wire
